// file: pkg/ppms_pkg.sv
/*
  Shared constants and types of the parallel port mode/status block:
  register indices, field positions, reset values, mode encodings.
  Assumes a 32-bit APB slave where each register index is one word.
*/
package ppms_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_OUT_STAT = 12'hF54;
  localparam logic [11:0] IDX_IN_STAT = 12'hF55;
  localparam logic [11:0] IDX_PEN_L = 12'hF56;
  localparam logic [11:0] IDX_PEN_H = 12'hF57;
  localparam logic [11:0] IDX_IN_A_L = 12'hF58;
  localparam logic [11:0] IDX_IN_A_H = 12'hF59;
  localparam logic [11:0] IDX_IN_B_L = 12'hF5A;
  localparam logic [11:0] IDX_IN_B_H = 12'hF5B;
  localparam logic [11:0] IDX_WAIT = 12'hF5C;
  localparam logic [11:0] IDX_MODE = 12'hF5D;
  localparam logic [11:0] IDX_CTRL_L = 12'hF5E;
  localparam logic [11:0] IDX_CTRL_H = 12'hF5F;
  localparam logic [11:0] IDX_OUT_B_L = 12'hF60;
  localparam logic [11:0] IDX_OUT_B_H = 12'hF61;
  localparam logic [11:0] IDX_ADDR_L = 12'hF6E;
  localparam logic [11:0] IDX_ADDR_H = 12'hF6F;

  // Field positions
  localparam int MODE_BUSY_BIT = 7;
  localparam int MODE_IRQ_LSB = 5;
  localparam int MODE_STEP_LSB = 3;
  localparam int MODE_WIDE_BIT = 2;
  localparam int MODE_PORT_LSB = 0;
  localparam int WAIT_SETUP_LSB = 6;
  localparam int WAIT_MAIN_LSB = 2;
  localparam int WAIT_HOLD_LSB = 0;
  localparam int STAT_SUM_BIT = 7;
  localparam int STAT_ERR_BIT = 6;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MUX_LSB = 3;
  localparam int CTRL_CSF_LSB = 6;
  localparam int ADDRH_CS1_BIT = 6;
  localparam int ADDRH_CS2_BIT = 7;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] OUT_EMPTY_RST = 4'hF;
  localparam logic [1:0] CSF_ON = 2'b10;
  localparam logic [3:0] MAIN_NONE = 4'h0;

  typedef enum logic [1:0] {
    PM_LEGACY = 2'b00,
    PM_ENHANCED = 2'b01,
    PM_MASTER2 = 2'b10,
    PM_MASTER1 = 2'b11
  } ppms_mode_e;

  typedef enum logic [1:0] {
    IRQ_NONE = 2'b00,
    IRQ_EACH = 2'b01,
    IRQ_STALL = 2'b10,
    IRQ_SLOT3 = 2'b11
  } ppms_irq_e;

  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_UP = 2'b01,
    STEP_DOWN = 2'b10,
    STEP_BUF = 2'b11
  } ppms_step_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_STROBE = 2'b10,
    PH_HOLD = 2'b11
  } ppms_phase_e;

endpackage

// file: testbench/ppms_ext_model.sv
/*
  External processor on the slave pins: one-cycle strobes on request.
  Assumes requests come from the bench on pclk edges.
*/
`timescale 1ns/1ns
module ppms_ext_model (
  input wire logic pclk,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_d,
  output logic cs,
  output logic wr,
  output logic rd,
  output logic [7:0] data = 8'h00
);
  // Select rises with each strobe; released data inverts so stale bytes never match
  always_ff @(posedge pclk) begin
    cs <= host_wr | host_rd;
    wr <= host_wr;
    rd <= host_rd;
    data <= host_wr ? host_d : ~data;
  end
endmodule // ppms_ext_model

// file: testbench/ppms_port_checker.sv
/*
  Concurrent checks on the ports of ppms_port.
  Assumes one clock pclk and the async active-low presetn.
*/
`timescale 1ns/1ns
module ppms_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic xfer_event,
  input wire logic cpu_stall,
  input wire logic write_strobe_pin_out,
  input wire logic write_strobe_pin_oe_n,
  input wire logic read_strobe_pin_oe_n,
  input wire logic [15:0] port_addr_pins_oe_n,
  input wire logic byte_enable_pin_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counters stand in for long repetitions the tools cannot unroll cheaply
  logic [5:0] stall_cnt;
  logic [4:0] str_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt <= 6'h00;
      str_cnt <= 5'h00;
    end else begin
      stall_cnt <= cpu_stall ? stall_cnt + 6'h01 : 6'h00;
      str_cnt <= write_strobe_pin_out ? str_cnt + 5'h01 : 5'h00;
    end
  end
  AST_STALL_PREADY: assert property (!pready |-> cpu_stall || $past(cpu_stall))
    else $error("pready low outside a stall");
  AST_STALL_NO_EVENT: assert property (cpu_stall |-> !xfer_event)
    else $error("event during stall");
  AST_EVENT_PULSE: assert property (xfer_event |=> !xfer_event)
    else $error("event longer than one cycle");
  AST_STALL_BOUND: assert property (stall_cnt < 6'h3C)
    else $error("stall never ends");
  AST_STROBE_BOUND: assert property (str_cnt <= 5'h10)
    else $error("strobe longer than sixteen cycles");
  AST_WR_DRIVEN: assert property (write_strobe_pin_out |-> !write_strobe_pin_oe_n)
    else $error("strobe active but not driven");
  AST_ADDR_OE: assert property (port_addr_pins_oe_n != 16'hFFFF |-> !read_strobe_pin_oe_n)
    else $error("address driven outside master mode");
  AST_BE_MASTER: assert property (byte_enable_pin_out |-> !write_strobe_pin_oe_n)
    else $error("byte enable outside master mode");
  cover property ($rose(cpu_stall));
  cover property (xfer_event);
  cover property ($fell(write_strobe_pin_out));
endmodule // ppms_port_checker
bind ppms_port ppms_port_checker i_ppms_port_checker (.pclk(pclk), .presetn(presetn), .pready(pready),
  .xfer_event(xfer_event), .cpu_stall(cpu_stall), .write_strobe_pin_out(write_strobe_pin_out),
  .write_strobe_pin_oe_n(write_strobe_pin_oe_n), .read_strobe_pin_oe_n(read_strobe_pin_oe_n),
  .port_addr_pins_oe_n(port_addr_pins_oe_n), .byte_enable_pin_out(byte_enable_pin_out));

// file: testbench/ppms_port_tb.sv
/*
  Bench for ppms_port: APB tasks, master, stall and slave tests.
  Assumes ppms_ext_model stands on the pin side.
*/
`timescale 1ns/1ns
module ppms_port_tb
  import ppms_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [15:0] paddr = 16'h0000, a_oen, exp_addr;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [7:0] d_in, d_out, d_oen, p_d, d_seen, host_d = 8'h00, w;
  logic rs, ws, cs, ws_out, cs_out, ev, stall, host_wr = 0, host_rd = 0;
  int err_count = 0, checks_done = 0, wr_hi, cs_hi, ev_n, stall_n, n;
  logic [7:0] cfg_w [4] = '{8'h04, 8'hC3, 8'hC7, 8'h00};
  int exp_wr [4] = '{2, 1, 2, 2};
  // Chip select also spans the done cycle before busy clears
  int exp_cs [4] = '{5, 2, 11, 0};
  assign d_in = (d_out & ~d_oen) | (p_d & d_oen);
  ppms_ext_model i_ppms_ext_model (.pclk(pclk), .host_wr(host_wr), .host_rd(host_rd), .host_d(host_d),
    .cs(cs), .wr(ws), .rd(rs), .data(p_d));
  ppms_port i_ppms_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .port_addr_pins_in(16'h0000), .port_addr_pins_out(), .port_addr_pins_oe_n(a_oen),
    .port_data_pins_in(d_in), .port_data_pins_out(d_out), .port_data_pins_oe_n(d_oen),
    .read_strobe_pin_in(rs), .read_strobe_pin_out(), .read_strobe_pin_oe_n(),
    .write_strobe_pin_in(ws), .write_strobe_pin_out(ws_out), .write_strobe_pin_oe_n(),
    .chip_select_pin_in(cs), .chip_select_pin_out(cs_out), .chip_select_pin_oe_n(),
    .byte_enable_pin_out(), .xfer_event(ev), .cpu_stall(stall));
  initial begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (ws_out === 1'b1) begin
      wr_hi++;
      d_seen = d_out;
    end
    if (d_oen === 8'h00 && cs_out === 1'b0) d_seen = d_out;
    if (cs_out === 1'b1) cs_hi++;
    if (ev === 1'b1) ev_n++;
    if (stall === 1'b1) stall_n++;
  end
  ////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // Waits on pready itself; only the watchdog cuts a hung access short
  task apb(input logic wrt, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wrt;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task rc(input logic [11:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, rdat);
  endtask
  task ext(input logic wrt, input logic [7:0] d);
    @(posedge pclk);
    host_wr <= wrt;
    host_rd <= !wrt;
    host_d <= d;
    @(posedge pclk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(IDX_OUT_STAT, 8'h8F, "out_stat");
    rc(IDX_IN_STAT, 8'h00, "in_stat");
    rc(IDX_MODE, 8'h00, "mode");
    apb(1'b0, 12'hF62, 32'h0);
    chk("unmapped_err", 1'b1, rerr);
    wr(IDX_CTRL_H, 8'h80);
    wr(IDX_PEN_H, 8'hFF);
    wr(IDX_PEN_L, 8'hFC);
    rc(IDX_PEN_L, 8'hFC, "pen_l");
    exp_addr = 16'h0010;
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = (i == 3) ? 8'h04 : 8'h00;
      wr(IDX_WAIT, cfg_w[i]);
      wr(IDX_MODE, 8'h2A | w);
      if (i == 0) wr(IDX_ADDR_L, 8'h10);
      chk("addr_oe", 16'h0003, a_oen);
      wr_hi = 0;
      cs_hi = 0;
      ev_n = 0;
      wr(IDX_IN_A_L, 32'h0000A55A);
      rc(IDX_MODE, 8'hAA | w, "busy");
      n = 0;
      do begin
        apb(1'b0, IDX_MODE, 32'h0);
        n++;
      end while (rdat[7] !== 1'b0 && n < 40);
      chk("busy_clear", 8'h2A | w, rdat);
      exp_addr += (i == 3) ? 16'h0002 : 16'h0001;
      rc(IDX_ADDR_L, exp_addr[7:0], "addr");
      chk("strobe_len", exp_wr[i], wr_hi);
      if (exp_cs[i] != 0) chk("cycle_len", exp_cs[i], cs_hi);
      chk("wr_data", (i == 3) ? 8'hA5 : 8'h5A, d_seen);
      chk("event", 1, ev_n);
    end
    $display("master test done");
    wr(IDX_WAIT, 8'h04);
    wr(IDX_MODE, 8'h42);
    stall_n = 0;
    wr(IDX_IN_A_L, 32'h00000077);
    rc(IDX_IN_A_L, 8'h77, "stall_rd");
    chk("stall_seen", 1'b1, stall_n != 0);
    repeat (40) @(posedge pclk);
    wr(IDX_MODE, 8'h33);
    wr(IDX_IN_A_L, 32'h0000003C);
    repeat (20) @(posedge pclk);
    rc(IDX_ADDR_L, 8'h14, "addr_down");
    chk("m1_data", 8'h3C, d_seen);
    $display("stall test done");
    wr(IDX_MODE, 8'h00);
    ext(1'b1, 8'hC3);
    rc(IDX_IN_STAT, 8'h01, "in_full");
    rc(IDX_IN_A_L, 8'hC3, "in_data");
    rc(IDX_IN_STAT, 8'h00, "in_clear");
    ext(1'b1, 8'h11);
    ext(1'b1, 8'h22);
    rc(IDX_IN_STAT, 8'h41, "overflow");
    ext(1'b0, 8'h00);
    rc(IDX_OUT_STAT, 8'hCF, "underflow");
    wr(IDX_ADDR_L, 8'h99);
    rc(IDX_OUT_STAT, 8'h4E, "out_fill");
    ext(1'b0, 8'h00);
    chk("slave_rd", 8'h99, d_seen);
    rc(IDX_OUT_STAT, 8'hCF, "out_drain");
    $display("slave test done");
    tally_and_finish;
  end
endmodule // ppms_port_tb

// file: verilog/ppms_port.sv
/*
  Parallel port mode, wait-state, pin-enable and status logic with an
  APB register slave. Master cycles use the wait-state sequencer; slave
  strobes from an external processor fill and drain four byte buffers.
  Assumes all pin inputs are synchronous to pclk and active high.
*/
// Functional notes
// - Busy flag reads bit 7 in master
// - Mode 11 event on buffer 3 access
// - Mode 10 stalls processor, no event
// - Mode 01 event per cycle; 00 none
// - Step 11 legacy slave uses buffer pointers
// - Master address steps up, down or holds
// - Wide select gives two byte transfers
// - Port modes 11 and 10 are masters
// - Port modes 01 and 00 are slaves
// - Setup wait is code plus one cycles
// - Strobe stretched by main wait code
// - Hold wait is code plus one cycles
// - Main code zero skips setup and hold
// - Upper enables give address or selects
// - Middle enables give address lines
// - Lowest enables give address or latches
// - Input full flags plus all-full summary
// - Write to full byte sets overflow
// - Output empty flags plus all-empty summary
// - Read of empty byte sets underflow
// - Address pair doubles as output buffer
// - Input pairs serve master and slave data
// - Select with write strobe captures data
`timescale 1ns/1ns
module ppms_port
  import ppms_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [15:0] port_addr_pins_in,
  output logic [15:0] port_addr_pins_out,
  output logic [15:0] port_addr_pins_oe_n,
  input wire logic [7:0] port_data_pins_in,
  output logic [7:0] port_data_pins_out,
  output logic [7:0] port_data_pins_oe_n,
  input wire logic read_strobe_pin_in,
  output logic read_strobe_pin_out,
  output logic read_strobe_pin_oe_n,
  input wire logic write_strobe_pin_in,
  output logic write_strobe_pin_out,
  output logic write_strobe_pin_oe_n,
  input wire logic chip_select_pin_in,
  output logic chip_select_pin_out,
  output logic chip_select_pin_oe_n,
  output logic byte_enable_pin_out,
  output logic xfer_event,
  output logic cpu_stall
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] wait_cfg, mode_cfg, pen_lo, pen_hi, ctrl_lo, ctrl_hi;
  logic [7:0] in_buf [4];
  logic [7:0] out_buf [4];
  logic [3:0] in_full, out_empty, next_in_full, next_out_empty;
  logic in_ovf, out_unf;
  logic [1:0] wptr, rptr, wslot, rslot;
  logic s_wr_q, s_rd_q;
  logic [7:0] s_data, s_dout;
  logic xfer_on, xfer_rd, beat_hi;
  logic [15:0] rd_word;
  logic rd_hit;
  ppms_phase_e phase;
  logic seq_done, seq_start, last_done;

  ppms_mode_e pmode;
  ppms_irq_e irq_mode_sel;
  ppms_step_e addr_step_sel;
  logic wide_data_sel, port_on, master, buffered;
  logic [15:0] pin_function_enable;

  assign pmode = ppms_mode_e'(mode_cfg[MODE_PORT_LSB +: 2]);
  assign irq_mode_sel = ppms_irq_e'(mode_cfg[MODE_IRQ_LSB +: 2]);
  assign addr_step_sel = ppms_step_e'(mode_cfg[MODE_STEP_LSB +: 2]);
  assign wide_data_sel = mode_cfg[MODE_WIDE_BIT];
  assign port_on = ctrl_hi[CTRL_EN_BIT];
  assign master = port_on && (pmode == PM_MASTER1 || pmode == PM_MASTER2);
  assign buffered = (pmode == PM_LEGACY) && (addr_step_sel == STEP_BUF);
  assign pin_function_enable = {pen_hi, pen_lo};

  ////////////////////////////////////////////////////////////////////////
  // Buffer slot behind a register index: {hit, slot}
  function automatic logic [2:0] in_slot(input logic [11:0] i);
    case (i)
      IDX_IN_A_L: in_slot = 3'b100;
      IDX_IN_A_H: in_slot = 3'b101;
      IDX_IN_B_L: in_slot = 3'b110;
      IDX_IN_B_H: in_slot = 3'b111;
      default: in_slot = 3'b000;
    endcase
  endfunction

  function automatic logic [2:0] out_slot(input logic [11:0] i);
    case (i)
      IDX_ADDR_L: out_slot = 3'b100;
      IDX_ADDR_H: out_slot = 3'b101;
      IDX_OUT_B_L: out_slot = 3'b110;
      IDX_OUT_B_H: out_slot = 3'b111;
      default: out_slot = 3'b000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  logic [11:0] idx;
  logic aligned, acc, wr_acc, rd_acc, data_hit;
  logic [2:0] isl, osl;

  assign idx = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:14] == '0);
  assign isl = in_slot(idx);
  assign osl = out_slot(idx);
  assign data_hit = (idx == IDX_IN_A_L) || (idx == IDX_IN_A_H);
  // Stall mode holds the access to the data register until the cycle ends
  assign pready = !(irq_mode_sel == IRQ_STALL && xfer_on && data_hit);
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite && aligned;
  assign rd_acc = acc && !pwrite && aligned;
  assign cpu_stall = xfer_on && (irq_mode_sel == IRQ_STALL);

  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    case (idx)
      IDX_OUT_STAT: rd_word = {8'h00, &out_empty, out_unf, 2'b00, out_empty};
      IDX_IN_STAT: rd_word = {8'h00, &in_full, in_ovf, 2'b00, in_full};
      IDX_PEN_L: rd_word = {8'h00, pen_lo};
      IDX_PEN_H: rd_word = {8'h00, pen_hi};
      IDX_WAIT: rd_word = {8'h00, wait_cfg};
      IDX_MODE: rd_word = {8'h00, xfer_on && master, mode_cfg[6:0]};
      IDX_CTRL_L: rd_word = {8'h00, ctrl_lo};
      IDX_CTRL_H: rd_word = {8'h00, ctrl_hi};
      IDX_IN_A_L: rd_word = wide_data_sel ? {in_buf[1], in_buf[0]} : {8'h00, in_buf[0]};
      IDX_IN_A_H: rd_word = {8'h00, in_buf[1]};
      IDX_IN_B_L: rd_word = {8'h00, in_buf[2]};
      IDX_IN_B_H: rd_word = {8'h00, in_buf[3]};
      IDX_ADDR_L: rd_word = {8'h00, out_buf[0]};
      IDX_ADDR_H: rd_word = {8'h00, out_buf[1]};
      IDX_OUT_B_L: rd_word = {8'h00, out_buf[2]};
      IDX_OUT_B_H: rd_word = {8'h00, out_buf[3]};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= {16'h0000, rd_word};
      pslverr <= !(rd_hit && aligned);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cfg <= REG_RST;
      mode_cfg <= REG_RST;
      pen_lo <= REG_RST;
      pen_hi <= REG_RST;
      ctrl_lo <= REG_RST;
      ctrl_hi <= REG_RST;
    end else if (wr_acc) begin
      // Timing and mode are frozen while a master cycle runs
      if (idx == IDX_WAIT && !xfer_on) begin
        wait_cfg <= pwdata[7:0];
      end
      if (idx == IDX_MODE && !xfer_on) begin
        mode_cfg <= {1'b0, pwdata[6:0]};
      end
      if (idx == IDX_PEN_L) begin
        pen_lo <= pwdata[7:0];
      end
      if (idx == IDX_PEN_H) begin
        pen_hi <= pwdata[7:0];
      end
      if (idx == IDX_CTRL_L) begin
        ctrl_lo <= pwdata[7:0];
      end
      if (idx == IDX_CTRL_H) begin
        ctrl_hi <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master cycle control
  logic trig;
  assign trig = master && !xfer_on && (rd_acc || wr_acc) && (idx == IDX_IN_A_L);
  assign last_done = seq_done && (!wide_data_sel || beat_hi);
  assign seq_start = trig || (seq_done && wide_data_sel && !beat_hi);

  ppms_wait_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(seq_start),
    .setup_code(wait_cfg[WAIT_SETUP_LSB +: 2]),
    .main_code(wait_cfg[WAIT_MAIN_LSB +: 4]),
    .hold_code(wait_cfg[WAIT_HOLD_LSB +: 2]),
    .phase(phase),
    .done(seq_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_on <= 1'b0;
      xfer_rd <= 1'b0;
      beat_hi <= 1'b0;
    end else if (trig) begin
      xfer_on <= 1'b1;
      xfer_rd <= !pwrite;
      beat_hi <= 1'b0;
    end else if (last_done) begin
      xfer_on <= 1'b0;
      beat_hi <= 1'b0;
    end else if (seq_done) begin
      beat_hi <= 1'b1;
    end
  end

  // Address step skips bit 14, which may carry a chip select
  logic [14:0] a15, next_a15;
  assign a15 = {out_buf[1][7], out_buf[1][5:0], out_buf[0]};

  always_comb begin
    case (addr_step_sel)
      STEP_UP: next_a15 = a15 + 15'h0001;
      STEP_DOWN: next_a15 = a15 - 15'h0001;
      default: next_a15 = a15;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave strobe tracking
  logic s_mode, s_wr, s_rd, wr_end, rd_beg, rd_end;
  logic [1:0] s_slot_w, s_slot_r;

  assign s_mode = port_on && !pmode[1];
  assign s_wr = s_mode && chip_select_pin_in && write_strobe_pin_in;
  assign s_rd = s_mode && chip_select_pin_in && read_strobe_pin_in;
  assign wr_end = s_wr_q && !s_wr;
  assign rd_beg = s_rd && !s_rd_q;
  assign rd_end = s_rd_q && !s_rd;
  // Legacy slave without stepping always uses slot 0
  assign s_slot_w = (pmode == PM_ENHANCED) ? port_addr_pins_in[1:0] : (buffered ? wptr : 2'b00);
  assign s_slot_r = (pmode == PM_ENHANCED) ? port_addr_pins_in[1:0] : (buffered ? rptr : 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_wr_q <= 1'b0;
      s_rd_q <= 1'b0;
      s_data <= REG_RST;
      s_dout <= REG_RST;
      wslot <= 2'b00;
      rslot <= 2'b00;
    end else begin
      s_wr_q <= s_wr;
      s_rd_q <= s_rd;
      if (s_wr) begin
        s_data <= port_data_pins_in;
        wslot <= s_slot_w;
      end
      if (rd_beg) begin
        s_dout <= out_buf[s_slot_r];
        rslot <= s_slot_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= 2'b00;
      rptr <= 2'b00;
    end else begin
      if (wr_end && buffered) begin
        wptr <= wptr + 2'b01;
      end
      if (rd_end && buffered) begin
        rptr <= rptr + 2'b01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input buffers: master data register and slave write bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 4; k++) begin
        in_buf[k] <= REG_RST;
      end
    end else if (trig && pwrite) begin
      in_buf[0] <= pwdata[7:0];
      if (wide_data_sel) begin
        in_buf[1] <= pwdata[15:8];
      end
    end else if (xfer_on && xfer_rd && phase == PH_STROBE) begin
      in_buf[{1'b0, beat_hi}] <= port_data_pins_in;
    end else if (wr_end) begin
      in_buf[wslot] <= s_data;
    end
  end

  // Output buffers; slots 0 and 1 are the master address pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 4; k++) begin
        out_buf[k] <= REG_RST;
      end
    end else if (wr_acc && osl[2] && !xfer_on) begin
      out_buf[osl[1:0]] <= pwdata[7:0];
    end else if (seq_done && master) begin
      out_buf[1] <= {next_a15[14], out_buf[1][ADDRH_CS1_BIT], next_a15[13:8]};
      out_buf[0] <= next_a15[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set wins over a software clear
  always_comb begin
    next_in_full = in_full;
    next_out_empty = out_empty;
    if (rd_acc && isl[2] && !master) begin
      next_in_full[isl[1:0]] = 1'b0;
    end
    if (wr_end) begin
      next_in_full[wslot] = 1'b1;
    end
    if (wr_acc && osl[2] && !master) begin
      next_out_empty[osl[1:0]] = 1'b0;
    end
    if (rd_end) begin
      next_out_empty[rslot] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_full <= 4'h0;
      out_empty <= OUT_EMPTY_RST;
      in_ovf <= 1'b0;
      out_unf <= 1'b0;
    end else begin
      in_full <= next_in_full;
      out_empty <= next_out_empty;
      if (wr_end && in_full[wslot]) begin
        in_ovf <= 1'b1;
      end else if (wr_acc && idx == IDX_IN_STAT && !pwdata[STAT_ERR_BIT]) begin
        in_ovf <= 1'b0;
      end
      if (rd_beg && out_empty[s_slot_r]) begin
        out_unf <= 1'b1;
      end else if (wr_acc && idx == IDX_OUT_STAT && !pwdata[STAT_ERR_BIT]) begin
        out_unf <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer event pulse
  logic ev_each, ev_slot3;
  assign ev_each = last_done || wr_end || rd_end;
  assign ev_slot3 = (wr_end && wslot == 2'b11) || (rd_end && rslot == 2'b11);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_event <= 1'b0;
    end else begin
      case (irq_mode_sel)
        IRQ_EACH: xfer_event <= ev_each;
        IRQ_SLOT3: xfer_event <= ev_slot3 && (buffered || pmode == PM_ENHANCED);
        default: xfer_event <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master pins
  logic strobe, csf_on, mux_on, addr_ph;
  logic [15:0] pin_val;
  assign strobe = xfer_on && (phase == PH_STROBE);
  assign csf_on = (ctrl_lo[CTRL_CSF_LSB +: 2] == CSF_ON);
  assign mux_on = (ctrl_hi[CTRL_MUX_LSB +: 2] != 2'b00);
  assign addr_ph = xfer_on && mux_on && (phase == PH_SETUP);

  always_comb begin
    pin_val = {out_buf[1], out_buf[0]};
    if (csf_on) begin
      pin_val[15:14] = {out_buf[1][ADDRH_CS2_BIT], out_buf[1][ADDRH_CS1_BIT]} & {2{xfer_on}};
    end
    if (mux_on) begin
      pin_val[1:0] = {2{addr_ph}};
    end
  end

  for (genvar i = 0; i < 16; i++) begin : g_pin
    assign port_addr_pins_out[i] = pin_val[i];
    assign port_addr_pins_oe_n[i] = !(pin_function_enable[i] && master);
  end

  always_comb begin
    if (pmode == PM_MASTER1) begin
      read_strobe_pin_out = xfer_on && xfer_rd;
      write_strobe_pin_out = strobe;
    end else begin
      read_strobe_pin_out = strobe && xfer_rd;
      write_strobe_pin_out = strobe && !xfer_rd;
    end
  end

  assign read_strobe_pin_oe_n = !master;
  assign write_strobe_pin_oe_n = !master;
  assign chip_select_pin_oe_n = !master;
  assign chip_select_pin_out = xfer_on && (!csf_on || out_buf[1][ADDRH_CS1_BIT]);
  assign byte_enable_pin_out = xfer_on && wide_data_sel && beat_hi;

  // Data pins: address phase, master write data, or slave read byte
  always_comb begin
    port_data_pins_out = s_dout;
    port_data_pins_oe_n = {8{!s_rd_q}};
    if (addr_ph) begin
      port_data_pins_out = out_buf[0];
      port_data_pins_oe_n = 8'h00;
    end else if (xfer_on && !xfer_rd) begin
      port_data_pins_out = in_buf[{1'b0, beat_hi}];
      port_data_pins_oe_n = 8'h00;
    end
  end

endmodule // ppms_port

// file: verilog/ppms_wait_seq.sv
/*
  Wait-state sequencer for one 8-bit master bus cycle: setup, strobe
  and hold phases counted in clock cycles (one clock is one Tcy).
  Assumes start is only raised while phase is idle.
*/
`timescale 1ns/1ns
module ppms_wait_seq
  import ppms_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [1:0] setup_code,
  input wire logic [3:0] main_code,
  input wire logic [1:0] hold_code,
  output ppms_phase_e phase,
  output logic done
);

  logic [3:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= PH_IDLE;
      cnt <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase)
        PH_IDLE: begin
          if (start) begin
            if (main_code == MAIN_NONE) begin
              phase <= PH_STROBE;
              cnt <= 4'h0;
            end else begin
              phase <= PH_SETUP;
              cnt <= {2'b00, setup_code};
            end
          end
        end
        PH_SETUP: begin
          if (cnt == 4'h0) begin
            phase <= PH_STROBE;
            cnt <= main_code;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        PH_STROBE: begin
          if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (main_code == MAIN_NONE) begin
            phase <= PH_IDLE;
            done <= 1'b1;
          end else begin
            phase <= PH_HOLD;
            cnt <= {2'b00, hold_code};
          end
        end
        PH_HOLD: begin
          if (cnt == 4'h0) begin
            phase <= PH_IDLE;
            done <= 1'b1;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

endmodule // ppms_wait_seq
